// ==== core/hppc_pkg.sv ====
// Package of offsets, field positions, reset values and constants for the hub power block
package hppc_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_PORTS = 3;
  localparam int ADDR_W = 4;

  // ==========================================================================
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] DESC_OFS = 4'h8;
  localparam logic [3:0] CLOCK_OFS = 4'hC;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_PWR_LSB = 0;
  localparam int CTRL_GANG_BIT = 3;
  localparam int CTRL_SUSP_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // ==========================================================================
  // Status register fields
  localparam int STAT_OC_LSB = 0;
  localparam int STAT_PWR_LSB = 4;
  localparam int STAT_GANG_BIT = 8;
  localparam int STAT_BUS_POWERED_SELECT_BIT = 9;
  localparam int STAT_THREE_BIT = 10;
  localparam int STAT_SUSP_BIT = 11;
  localparam int STAT_SLOW_LSB = 12;

  // ==========================================================================
  // Descriptor register fields
  localparam int DESC_COMPOUND_BIT = 8;
  localparam int DESC_NPORT_LSB = 16;

  // ==========================================================================
  // Clock register fields
  localparam int CLK_XTAL_BIT = 0;
  localparam int CLK_PLLPD_BIT = 1;
  localparam int CLK_OSCPD_BIT = 2;
  localparam int CLK_MULT_LSB = 8;

  // ==========================================================================
  // Hub descriptor removable-field encodings per strap setting
  localparam logic [7:0] REMOV_NONE = 8'h00;
  localparam logic [7:0] REMOV_P1 = 8'h02;
  localparam logic [7:0] REMOV_P12 = 8'h06;
  localparam logic [7:0] REMOV_P123 = 8'h0E;
  localparam logic [1:0] STRAP_NONE = 2'h0;
  localparam logic [1:0] STRAP_P1 = 2'h1;
  localparam logic [1:0] STRAP_P12 = 2'h2;
  localparam logic [1:0] STRAP_ALL = 2'h3;

  // ==========================================================================
  // Clock plan: reference and core frequency in MHz
  localparam int REF_CLK_MHZ = 6;
  localparam int CORE_CLK_MHZ = 48;
  localparam logic [7:0] PLL_MULT = 8'(CORE_CLK_MHZ / REF_CLK_MHZ);

  // ==========================================================================
  // Strap capture delay after reset release, in cycles
  localparam logic [2:0] STRAP_WAIT = 3'h4;

endpackage : hppc_pkg

// ==== core/hppc_top.sv ====
// Hub port power, clock source and descriptor strap logic with Avalon-MM registers
// Behaviour
// - Overcurrent turns off that port's power
// - Ganged: all enables together, any overcurrent
// - Per-port: each port handled on its own
// - Bus/self power times ganged/per-port: four modes
// - Clock-mode low: core runs from PLL
// - Clock-mode high: direct input, PLL powered down
// - Clock-mode high: oscillator cell powered down
// - PLL multiplies 6 MHz to 48 MHz
// - Suspend reached by disabling the clock
// - Port-count pin low three ports, high two
// - Straps 00: removable field all zero
// - Straps 01: bit 1 set
// - Straps 10: bits 1 and 2 set
// - Straps 11: all ports fixed, by count
// - Compound bit set unless straps 00
// - Slew rate follows attached device speed
// - External memory high: ganged from data pin
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
module hppc_top #(
  parameter int NUM_PORTS = hppc_pkg::NUM_PORTS
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Avalon-MM slave
  input wire logic [hppc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Port power pins
  input wire logic [NUM_PORTS-1:0] overcurrent_sense_b_i,
  output logic [NUM_PORTS-1:0] port_power_enable_o,
  // Configuration pins
  input wire logic bus_powered_select_i,
  input wire logic external_memory_select_i,
  input wire logic eeprom_data_line_i,
  input wire logic three_port_select_i,
  input wire logic [1:0] fixed_port_straps_i,
  input wire logic clock_mode_i,
  // Downstream speed from transceivers
  input wire logic [NUM_PORTS-1:0] port_low_speed_i,
  output logic [NUM_PORTS-1:0] port_slow_slew_o,
  // Clock source control
  output logic core_clk_from_xtal_o,
  output logic analog_pll_powerdown_o,
  output logic oscillator_powerdown_o,
  output logic [7:0] analog_pll_mult_o,
  output logic core_clk_enable_o,
  output logic suspend_status_o,
  // Hub descriptor fields
  output logic [7:0] device_removable_o,
  output logic hub_compound_o,
  output logic ganged_mode_o,
  output logic bus_powered_o
);

  // ==========================================================================
  // Pin input filter
  localparam int PIN_W = NUM_PORTS + 8;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_ff;
  logic [PIN_W-1:0] pin_s2_ff;
  logic [PIN_W-1:0] pin_s3_ff;
  logic [PIN_W-1:0] pin_ff;

  // Overcurrent pins are active low, flipped here so all logic is active high
  assign pin_raw = {~overcurrent_sense_b_i, bus_powered_select_i, external_memory_select_i,
                    eeprom_data_line_i, three_port_select_i, fixed_port_straps_i,
                    clock_mode_i, 1'b0};

  // First stage read only by the second; a change counts once stages two and three agree
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
      pin_ff <= '0;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff <= (pin_s2_ff & pin_s3_ff) | ((pin_s2_ff | pin_s3_ff) & pin_ff);
    end
  end

  logic [NUM_PORTS-1:0] oc_sync;
  logic bus_pwr_sync;
  logic ext_mem_sync;
  logic data_pin_sync;
  logic np3_sync;
  logic [1:0] straps_sync;
  logic clk_mode_sync;

  assign oc_sync = pin_ff[PIN_W-1 -: NUM_PORTS];
  assign bus_pwr_sync = pin_ff[7];
  assign ext_mem_sync = pin_ff[6];
  assign data_pin_sync = pin_ff[5];
  assign np3_sync = pin_ff[4];
  assign straps_sync = pin_ff[3:2];
  assign clk_mode_sync = pin_ff[1];

  // ==========================================================================
  // Bus handshake: one wait cycle, then the access completes
  logic bus_req;
  logic bus_done;
  logic wait_ff;
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_done = bus_req & ~wait_ff;
  // Waitrequest idles high and drops for the single completing cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_ff <= 1'b1;
    end else if (bus_done) begin
      wait_ff <= 1'b1;
    end else if (bus_req) begin
      wait_ff <= 1'b0;
    end
  end

  logic wr_ctrl;
  logic wr_status;
  assign wr_ctrl = bus_done & avs_write_i & (avs_address_i == hppc_pkg::CTRL_OFS) &
                   avs_byteenable_i[0];
  assign wr_status = bus_done & avs_write_i & (avs_address_i == hppc_pkg::STATUS_OFS) &
                     avs_byteenable_i[0];

  // ==========================================================================
  // Control register
  logic [NUM_PORTS-1:0] pwr_req_ff;
  logic gang_sw_ff;
  logic suspend_ff;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwr_req_ff <= hppc_pkg::CTRL_RESET[hppc_pkg::CTRL_PWR_LSB +: NUM_PORTS];
      gang_sw_ff <= hppc_pkg::CTRL_RESET[hppc_pkg::CTRL_GANG_BIT];
      suspend_ff <= hppc_pkg::CTRL_RESET[hppc_pkg::CTRL_SUSP_BIT];
    end else if (wr_ctrl) begin
      pwr_req_ff <= avs_writedata_i[hppc_pkg::CTRL_PWR_LSB +: NUM_PORTS];
      gang_sw_ff <= avs_writedata_i[hppc_pkg::CTRL_GANG_BIT];
      suspend_ff <= avs_writedata_i[hppc_pkg::CTRL_SUSP_BIT];
    end
  end

  // ==========================================================================
  // Power mode selection
  logic ganged;
  logic [NUM_PORTS-1:0] port_exists;
  // With external memory selected the shared pin carries the ganged setting
  assign ganged = ext_mem_sync ? data_pin_sync : gang_sw_ff;
  // Two-port hub keeps the third port permanently unpowered
  always_comb begin
    port_exists = '1;
    if (np3_sync) begin
      port_exists[NUM_PORTS-1] = 1'b0;
    end
  end

  // ==========================================================================
  // Overcurrent sticky flags; a new event beats a same-cycle clear
  logic [NUM_PORTS-1:0] oc_flag_ff;
  logic [NUM_PORTS-1:0] oc_clr;

  assign oc_clr = wr_status ? avs_writedata_i[hppc_pkg::STAT_OC_LSB +: NUM_PORTS] : '0;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oc_flag_ff <= '0;
    end else begin
      oc_flag_ff <= (oc_flag_ff & ~oc_clr) | (oc_sync & port_exists);
    end
  end

  // ==========================================================================
  // Port power enables
  logic [NUM_PORTS-1:0] nxt_pwr;
  logic [NUM_PORTS-1:0] pwr_ff;
  logic oc_any;
  assign oc_any = |(oc_flag_ff | (oc_sync & port_exists));
  always_comb begin
    if (ganged) begin
      // One request bit and any overcurrent steer every port at once
      nxt_pwr = (pwr_req_ff[0] && !oc_any) ? port_exists : '0;
    end else begin
      // Each port only sees its own request and its own sense line
      nxt_pwr = pwr_req_ff & ~oc_flag_ff & ~oc_sync & port_exists;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwr_ff <= '0;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end
  assign port_power_enable_o = pwr_ff;

  // ==========================================================================
  // Mode outputs, registered for clean pins
  logic ganged_ff;
  logic bus_pwr_ff;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ganged_ff <= 1'b0;
      bus_pwr_ff <= 1'b0;
    end else begin
      ganged_ff <= ganged;
      bus_pwr_ff <= bus_pwr_sync;
    end
  end

  assign ganged_mode_o = ganged_ff;
  assign bus_powered_o = bus_pwr_ff;

  // ==========================================================================
  // Slew selection follows the speed reported by each transceiver
  logic [NUM_PORTS-1:0] slew_ff;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slew_ff <= '0;
    end else begin
      slew_ff <= port_low_speed_i & port_exists;
    end
  end

  assign port_slow_slew_o = slew_ff;

  // ==========================================================================
  // Clock source control
  logic xtal_ff;
  logic pll_pd_ff;
  logic osc_pd_ff;
  logic clk_en_ff;
  logic susp_out_ff;
  logic [7:0] mult_ff; // Fixed 6 to 48 multiplier, unused while bypassed
  // Suspend stops the clock, so only a stoppable crystal allows low power
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xtal_ff <= 1'b0;
      pll_pd_ff <= 1'b0;
      osc_pd_ff <= 1'b0;
      clk_en_ff <= 1'b1;
      susp_out_ff <= 1'b0;
      mult_ff <= 8'h00;
    end else begin
      xtal_ff <= clk_mode_sync;
      pll_pd_ff <= clk_mode_sync | suspend_ff;
      osc_pd_ff <= clk_mode_sync | suspend_ff;
      clk_en_ff <= ~suspend_ff;
      susp_out_ff <= suspend_ff;
      mult_ff <= hppc_pkg::PLL_MULT;
    end
  end

  assign core_clk_from_xtal_o = xtal_ff;
  assign analog_pll_powerdown_o = pll_pd_ff;
  assign oscillator_powerdown_o = osc_pd_ff;
  assign core_clk_enable_o = clk_en_ff;
  assign suspend_status_o = susp_out_ff;
  assign analog_pll_mult_o = mult_ff;

  // ==========================================================================
  // Strap capture after reset release; later changes are ignored
  logic [2:0] strap_cnt_ff;
  logic strap_done_ff;
  logic [1:0] straps_ff;
  logic np3_ff;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_cnt_ff <= 3'h0;
      strap_done_ff <= 1'b0;
      straps_ff <= 2'h0;
      np3_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      if (strap_cnt_ff == hppc_pkg::STRAP_WAIT) begin
        strap_done_ff <= 1'b1;
        straps_ff <= straps_sync;
        np3_ff <= np3_sync;
      end else begin
        strap_cnt_ff <= strap_cnt_ff + 3'h1;
      end
    end
  end

  // ==========================================================================
  // Hub descriptor fields from straps
  logic [7:0] nxt_remov;
  logic [7:0] remov_ff;
  logic compound_ff;
  always_comb begin
    case (straps_ff)
      hppc_pkg::STRAP_NONE: nxt_remov = hppc_pkg::REMOV_NONE;
      hppc_pkg::STRAP_P1: nxt_remov = hppc_pkg::REMOV_P1;
      hppc_pkg::STRAP_P12: nxt_remov = hppc_pkg::REMOV_P12;
      hppc_pkg::STRAP_ALL: nxt_remov = np3_ff ? hppc_pkg::REMOV_P12 : hppc_pkg::REMOV_P123;
      default: nxt_remov = hppc_pkg::REMOV_NONE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      remov_ff <= 8'h00;
      compound_ff <= 1'b0;
    end else begin
      remov_ff <= nxt_remov;
      compound_ff <= (straps_ff != hppc_pkg::STRAP_NONE);
    end
  end

  assign device_removable_o = remov_ff;
  assign hub_compound_o = compound_ff;

  // ==========================================================================
  // Read data mux, registered while waitrequest is still high
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (avs_address_i)
      hppc_pkg::CTRL_OFS: begin
        nxt_rdata[hppc_pkg::CTRL_PWR_LSB +: NUM_PORTS] = pwr_req_ff;
        nxt_rdata[hppc_pkg::CTRL_GANG_BIT] = gang_sw_ff;
        nxt_rdata[hppc_pkg::CTRL_SUSP_BIT] = suspend_ff;
      end
      hppc_pkg::STATUS_OFS: begin
        nxt_rdata[hppc_pkg::STAT_OC_LSB +: NUM_PORTS] = oc_flag_ff;
        nxt_rdata[hppc_pkg::STAT_PWR_LSB +: NUM_PORTS] = pwr_ff;
        nxt_rdata[hppc_pkg::STAT_GANG_BIT] = ganged_ff;
        nxt_rdata[hppc_pkg::STAT_BUS_POWERED_SELECT_BIT] = bus_pwr_ff;
        nxt_rdata[hppc_pkg::STAT_THREE_BIT] = ~np3_ff;
        nxt_rdata[hppc_pkg::STAT_SUSP_BIT] = susp_out_ff;
        nxt_rdata[hppc_pkg::STAT_SLOW_LSB +: NUM_PORTS] = slew_ff;
      end
      hppc_pkg::DESC_OFS: begin
        nxt_rdata[7:0] = remov_ff;
        nxt_rdata[hppc_pkg::DESC_COMPOUND_BIT] = compound_ff;
        nxt_rdata[hppc_pkg::DESC_NPORT_LSB +: 2] = np3_ff ? 2'h2 : 2'h3;
      end
      hppc_pkg::CLOCK_OFS: begin
        nxt_rdata[hppc_pkg::CLK_XTAL_BIT] = xtal_ff;
        nxt_rdata[hppc_pkg::CLK_PLLPD_BIT] = pll_pd_ff;
        nxt_rdata[hppc_pkg::CLK_OSCPD_BIT] = osc_pd_ff;
        nxt_rdata[hppc_pkg::CLK_MULT_LSB +: 8] = mult_ff;
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read_i && wait_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;

endmodule : hppc_top

// ==== verification/hppc_top_monitor.sv ====
// Checker of hub port power, clock source and descriptor outputs
module hppc_top_monitor #(
  parameter int NUM_PORTS = 3
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Port power
  input wire logic [NUM_PORTS-1:0] overcurrent_sense_b_i,
  input wire logic [NUM_PORTS-1:0] port_power_enable_o,
  input wire logic three_port_select_i,
  input wire logic ganged_mode_o,
  // Clock source
  input wire logic clock_mode_i,
  input wire logic core_clk_from_xtal_o,
  input wire logic analog_pll_powerdown_o,
  input wire logic [7:0] analog_pll_mult_o,
  input wire logic core_clk_enable_o,
  input wire logic suspend_status_o,
  // Descriptor
  input wire logic [7:0] device_removable_o,
  input wire logic hub_compound_o
);
  // Six MHz reference times eight gives the 48 MHz core
  localparam logic [7:0] MULT = 8'h08;
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Two low samples pass the filter; the faulted port's enable is off four samples later
  property p_oc_cuts_power;
    !overcurrent_sense_b_i[1] [*2] |-> ##4 !port_power_enable_o[1];
  endproperty
  a_oc_cuts_power: assert property (p_oc_cuts_power)
    else $error("port kept powered under overcurrent");
  property p_gang_equal;
    ganged_mode_o && $past(ganged_mode_o, 8) |-> port_power_enable_o[1] == port_power_enable_o[0];
  endproperty
  a_gang_equal: assert property (p_gang_equal)
    else $error("ganged enables differ");
  property p_two_port_off;
    three_port_select_i [*8] |-> !port_power_enable_o[2];
  endproperty
  a_two_port_off: assert property (p_two_port_off)
    else $error("third port powered in two-port mode");
  property p_pll_source;
    !clock_mode_i [*7] |-> !core_clk_from_xtal_o;
  endproperty
  a_pll_source: assert property (p_pll_source)
    else $error("core not on pll with mode low");
  property p_xtal_source;
    clock_mode_i [*7] |-> core_clk_from_xtal_o && analog_pll_powerdown_o;
  endproperty
  a_xtal_source: assert property (p_xtal_source)
    else $error("direct clock without pll powerdown");
  property p_mult;
    $past(rst_b_i) |-> analog_pll_mult_o == MULT;
  endproperty
  a_mult: assert property (p_mult)
    else $error("pll multiplier wrong");
  property p_susp_clk;
    $rose(suspend_status_o) |-> ##[0:2] !core_clk_enable_o;
  endproperty
  a_susp_clk: assert property (p_susp_clk)
    else $error("clock still enabled in suspend");
  property p_compound;
    hub_compound_o == (device_removable_o != 8'h00);
  endproperty
  a_compound: assert property (p_compound)
    else $error("compound bit disagrees with removable field");
endmodule : hppc_top_monitor

bind hppc_top hppc_top_monitor #(.NUM_PORTS(NUM_PORTS)) i_mon (
  .core_clk_i, .rst_b_i, .overcurrent_sense_b_i, .port_power_enable_o,
  .three_port_select_i, .ganged_mode_o, .clock_mode_i, .core_clk_from_xtal_o,
  .analog_pll_powerdown_o, .analog_pll_mult_o, .core_clk_enable_o, .suspend_status_o,
  .device_removable_o, .hub_compound_o
);

// ==== verification/hppc_switch_model.sv ====
// Model of the external port power switches and reference oscillator
module hppc_switch_model (
  // Clock
  input wire logic clk_i,
  // Switch side
  input wire logic [2:0] power_enable_i,
  input wire logic [2:0] fault_i,
  output logic [2:0] overcurrent_sense_b_o,
  // Oscillator side
  input wire logic suspend_status_i,
  output logic ref_osc_o
);
  // Only a powered, loaded switch flags; the flag drops once power is cut
  always_ff @(posedge clk_i) begin
    overcurrent_sense_b_o <= ~(fault_i & power_enable_i);
  end
  // Reference held low while the hub is suspended
  always_ff @(posedge clk_i) begin
    ref_osc_o <= suspend_status_i ? 1'b0 : (ref_osc_o !== 1'b1);
  end
endmodule : hppc_switch_model

// ==== verification/tb.sv ====
// Self-checking bench of the hub port power and configuration block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Signals
  logic core_clk_i, rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [2:0] overcurrent_sense_b_i, port_power_enable_o, port_low_speed_i;
  logic [2:0] port_slow_slew_o, fault;
  logic bus_powered_select_i, external_memory_select_i, eeprom_data_line_i;
  logic three_port_select_i, clock_mode_i, core_clk_from_xtal_o, analog_pll_powerdown_o;
  logic oscillator_powerdown_o, core_clk_enable_o, suspend_status_o, hub_compound_o;
  logic ganged_mode_o, bus_powered_o, ref_osc;
  logic [1:0] fixed_port_straps_i;
  logic [7:0] analog_pll_mult_o, device_removable_o;
  int error_cnt = 0;
  int cmp_count = 0;
  // Design and far-side switches
  hppc_top #(.NUM_PORTS(3)) i_dut (
    .core_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .overcurrent_sense_b_i,
    .port_power_enable_o, .bus_powered_select_i, .external_memory_select_i,
    .eeprom_data_line_i, .three_port_select_i, .fixed_port_straps_i, .clock_mode_i,
    .port_low_speed_i, .port_slow_slew_o, .core_clk_from_xtal_o, .analog_pll_powerdown_o,
    .oscillator_powerdown_o, .analog_pll_mult_o, .core_clk_enable_o, .suspend_status_o,
    .device_removable_o, .hub_compound_o, .ganged_mode_o, .bus_powered_o
  );
  hppc_switch_model i_sw (
    .clk_i(core_clk_i), .power_enable_i(port_power_enable_o), .fault_i(fault),
    .overcurrent_sense_b_o(overcurrent_sense_b_i), .suspend_status_i(suspend_status_o),
    .ref_osc_o(ref_osc)
  );
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge core_clk_i iff avs_waitrequest_o === 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  // Straps are latched once after release, so each setting needs a reset
  task automatic reset_dut(input logic [1:0] straps, input logic two_port);
    rst_b_i <= 1'b0;
    fixed_port_straps_i <= straps;
    three_port_select_i <= two_port;
    cyc(16);
    rst_b_i <= 1'b1;
    cyc(10);
  endtask : reset_dut
  // ==========================================================================
  // Scenarios
  task automatic t_straps;
    logic [31:0] tab = 32'h0E06_0200;
    for (int s = 0; s < 8; s++) begin
      reset_dut(2'(s), s[2]);
      bus(1'b0, 4'h8, 32'h0000_0000);
      chk(device_removable_o, s == 7 ? 8'h06 : tab[8*s[1:0] +: 8]);
      chk(hub_compound_o, s[1:0] != 2'b00);
      chk(rd[17:16], s[2] ? 2'h2 : 2'h3);
    end
  endtask : t_straps
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      bus_powered_select_i <= m[0];
      external_memory_select_i <= 1'b1;
      eeprom_data_line_i <= m[1];
      cyc(8);
      chk(bus_powered_o, m[0]);
      chk(ganged_mode_o, m[1]);
    end
    external_memory_select_i <= 1'b0;
    cyc(8);
    chk(ganged_mode_o, 1'b0);
  endtask : t_modes
  task automatic t_perport;
    bus(1'b1, 4'h0, 32'h0000_0007);
    cyc(8);
    chk(port_power_enable_o, 3'h7);
    fault <= 3'h2;
    cyc(10);
    chk(port_power_enable_o, 3'h5);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(rd[2:0], 3'h2);
    fault <= 3'h0;
    bus(1'b1, 4'h4, 32'h0000_0007);
    bus(1'b1, 4'h0, 32'h0000_0007);
    cyc(8);
    chk(port_power_enable_o, 3'h7);
  endtask : t_perport
  task automatic t_ganged;
    bus(1'b1, 4'h0, 32'h0000_0009);
    cyc(8);
    chk(port_power_enable_o, 3'h7);
    fault <= 3'h4;
    cyc(10);
    chk(port_power_enable_o, 3'h0);
    fault <= 3'h0;
    bus(1'b1, 4'h4, 32'h0000_0007);
    bus(1'b1, 4'h0, 32'h0000_0000);
  endtask : t_ganged
  task automatic t_ports_slew;
    three_port_select_i <= 1'b1;
    bus(1'b1, 4'h0, 32'h0000_0007);
    cyc(8);
    chk(port_power_enable_o, 3'h3);
    three_port_select_i <= 1'b0;
    bus(1'b1, 4'h0, 32'h0000_0000);
    port_low_speed_i <= 3'h5;
    cyc(8);
    chk(port_slow_slew_o, 3'h5);
    port_low_speed_i <= 3'h2;
    cyc(2);
    chk(port_slow_slew_o, 3'h2);
  endtask : t_ports_slew
  task automatic t_clock;
    for (int c = 0; c < 2; c++) begin
      clock_mode_i <= c[0];
      cyc(8);
      bus(1'b0, 4'hC, 32'h0000_0000);
      chk(rd[15:0], c ? 16'h0807 : 16'h0800);
      chk(oscillator_powerdown_o, c[0]);
    end
    clock_mode_i <= 1'b0;
    bus(1'b0, 4'h2, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask : t_clock
  task automatic t_suspend;
    bus(1'b1, 4'h0, 32'h0000_0010);
    cyc(3);
    chk({suspend_status_o, core_clk_enable_o, analog_pll_powerdown_o}, 3'h5);
    bus(1'b1, 4'h0, 32'h0000_0000);
    cyc(3);
    chk({suspend_status_o, core_clk_enable_o}, 2'h1);
  endtask : t_suspend
  // ==========================================================================
  // Run control
  task automatic end_sim;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // Clock of 100 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  // Main sequence
  initial begin
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    avs_byteenable_i = 4'hF;
    {fault, port_low_speed_i, bus_powered_select_i, clock_mode_i} = '0;
    {external_memory_select_i, eeprom_data_line_i} = '0;
    rst_b_i = 1'b0;
    t_straps();
    reset_dut(2'h0, 1'b0);
    t_modes();
    t_perport();
    t_ganged();
    t_ports_slew();
    t_clock();
    t_suspend();
    end_sim();
  end
  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    cyc(20000);
    error_cnt++;
    end_sim();
  end
endmodule : tb
